// ---- design/sysclk_pkg.sv ----
// Purpose: Shared constants and types for the system clock and power-mode
//          controller.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Register offsets are byte addresses.
package sysclk_pkg;

  // Register byte offsets
  localparam logic [7:0] SYSCLK_CTRL_OFS  = 8'h00;
  localparam logic [7:0] FAST_OSC_OFS     = 8'h04;
  localparam logic [7:0] PWR_STATUS_OFS   = 8'h08;
  localparam logic [7:0] WAKE_ENABLE_OFS  = 8'h0C;

  // System clock control fields
  localparam int SEL_MSB        = 7;
  localparam int SEL_LSB        = 5;
  localparam int FAST_KEEP_BIT  = 1;
  localparam int SLOW_KEEP_BIT  = 0;

  // Fast oscillator control fields
  localparam int FAST_STABLE_BIT = 1;
  localparam int FAST_EN_BIT     = 0;

  // Power status fields
  localparam int PDF_BIT      = 0;
  localparam int TIMEOUT_BIT  = 1;
  localparam int CAUSE_LSB    = 2;

  // Clock select code for the low-speed source
  localparam logic [2:0] SEL_LOW_SPEED = 3'h7;

  // Reset values
  localparam logic [2:0] SEL_RESET       = 3'h0;
  localparam logic       FAST_KEEP_RESET = 1'h0;
  localparam logic       SLOW_KEEP_RESET = 1'h0;
  localparam logic       FAST_EN_RESET   = 1'h1;

  // Power state of the core
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_HALT_SLOW_CLOCK_ON,
    ST_HALT_BOTH_CLOCKS_ON,
    ST_HALT_FAST_CLOCK_ON,
    ST_WAKE
  } power_state_t;

  // Cause of the last wake-up
  typedef struct packed {
    logic wdt;
    logic irq;
    logic pin;
  } wake_cause_t;

  // Oscillator run requests
  typedef struct packed {
    logic fast;
    logic slow;
  } osc_run_t;

endpackage

// ---- design/sysclk_power_mode_ctrl.sv ----
// Purpose: System clock selection, halt power modes and wake-up control.
// Assumes: Core pulses HALT and CLR_WDT for one CLK cycle; oscillator ready
//          lines and port pins are asynchronous and are synchronised here.
// Notes:   Registers reached over APB with zero wait states.
// Behaviour
// - Select field picks divided fast or low-speed clock
// - Unimplemented control bits read as zero
// - Fast-keep bit keeps fast oscillator during halt
// - Slow-keep bit keeps slow oscillator during halt
// - Fast oscillator enable bit, read-write
// - Stable flag cleared on enable, set when stable
// - Halt chooses sleep or idle; CPU clock stops
// - Both keep bits low enters sleep
// - Fast-keep low, slow-keep high: slow clock idle
// - Both keep bits high: both clocks idle
// - Fast-keep high, slow-keep low: fast clock idle
// - Entry sets power-down flag, clears timeout flag
// - State and registers held while halted
// - Halt clears watchdog; runs only if enabled
// - Code 111 switches to slow once stable
// - Back to fast via codes 000-110; poll flag
// - Wake on pin edge, interrupt, watchdog overflow
// - Power-down flag cleared only by reset, clear-watchdog
// - Watchdog wake sets timeout, resets PC and SP
// - Pin wake resumes after the halt
// - Blocked interrupt wake resumes after halt, stays pending
// - Serviceable interrupt wake takes interrupt at once
// - Already pending interrupt cannot cause wake
// - Sleep keeps slow oscillator only for watchdog
// - In slow mode fast oscillator follows enable
`timescale 1ns/1ps
`default_nettype none
module sysclk_power_mode_ctrl
  import sysclk_pkg::*;
#(
  parameter int NPINS = 14,
  parameter int NIRQ  = 8
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Core requests
  input  wire logic              HALT,
  input  wire logic              CLR_WDT,
  input  wire logic [NIRQ-1:0]   IRQ_FLAGS,
  input  wire logic [NIRQ-1:0]   IRQ_ENABLES,
  input  wire logic              STACK_FULL,
  // Watchdog side
  input  wire logic              WDT_ENABLE,
  input  wire logic              WDT_OVERFLOW,
  output logic                   WDT_CLEAR,
  output logic                   WDT_RUN,
  // Port pins, asynchronous
  input  wire logic [NPINS-1:0]  PORT_PINS,
  // Oscillators, ready lines asynchronous
  input  wire logic              FAST_OSC_READY,
  input  wire logic              SLOW_OSC_READY,
  output logic                   FAST_OSC_RUN,
  output logic                   SLOW_OSC_RUN,
  // System clock control
  output logic                   CPU_CLK_EN,
  output logic [2:0]             SYSCLK_DIV_SEL,
  output logic                   SYSCLK_USE_SLOW,
  // Wake-up results to the core
  output logic                   RESUME_NEXT,
  output logic                   TAKE_IRQ,
  output logic                   RESET_PC_SP,
  output logic [2:0]             POWER_MODE
);

  // Control registers
  logic [2:0]        sysclk_select;        // Clock select field
  logic              fast_osc_halt_keep;   // Fast oscillator kept in halt
  logic              slow_osc_halt_keep;   // Slow oscillator kept in halt
  logic              fast_osc_enable;      // Fast oscillator enable
  logic              fast_osc_stable_flag; // Fast oscillator stable
  logic              power_down_flag;      // Set on halt entry
  logic              watchdog_timeout_flag;// Set on watchdog wake
  logic [NPINS-1:0]  port_wake_enable;     // Pin wake enables
  wake_cause_t       last_cause;           // Latest wake cause

  // Power state
  power_state_t      state;
  power_state_t      next_state;
  wake_cause_t       cause;                // Cause held through wake
  logic [NIRQ-1:0]   irq_masked;           // Requests pending at entry
  logic              use_slow;             // System clock on low speed

  // Synchronisers: first stages feed second stages only
  logic [NPINS-1:0]  pin_meta;
  logic [NPINS-1:0]  pin_sync;
  logic [NPINS-1:0]  pin_prev;
  logic              fast_rdy_meta;
  logic              fast_rdy_sync;
  logic              slow_rdy_meta;
  logic              slow_rdy_sync;
  logic              fast_run_prev;        // Detects oscillator restart

  // Synchronise pins and oscillator ready lines
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pin_meta      <= '1;
      pin_sync      <= '1;
      pin_prev      <= '1;
      fast_rdy_meta <= 1'b0;
      fast_rdy_sync <= 1'b0;
      slow_rdy_meta <= 1'b0;
      slow_rdy_sync <= 1'b0;
    end else begin
      pin_meta      <= PORT_PINS;
      pin_sync      <= pin_meta;
      pin_prev      <= pin_sync;
      fast_rdy_meta <= FAST_OSC_READY;
      fast_rdy_sync <= fast_rdy_meta;
      slow_rdy_meta <= SLOW_OSC_READY;
      slow_rdy_sync <= slow_rdy_meta;
    end
  end

  // APB decode
  wire               setup     = PSEL && !PENABLE;
  wire               access    = PSEL && PENABLE;
  wire               hit_ctrl  = (PADDR == SYSCLK_CTRL_OFS);
  wire               hit_fast  = (PADDR == FAST_OSC_OFS);
  wire               hit_stat  = (PADDR == PWR_STATUS_OFS);
  wire               hit_wake  = (PADDR == WAKE_ENABLE_OFS);
  wire               mapped    = hit_ctrl || hit_fast || hit_stat ||
                                 hit_wake;
  wire               halted    = (state != ST_RUN);
  // Writes from software are dropped while the core is halted
  wire               wr_ok     = access && PWRITE && mapped && !halted;
  wire               wr_ctrl   = wr_ok && hit_ctrl;
  wire               wr_fast   = wr_ok && hit_fast;
  wire               wr_wake   = wr_ok && hit_wake;

  // Read mux; unimplemented bits are zero
  logic [31:0]       rd_value;
  always_comb begin
    rd_value = 32'h0;
    if (hit_ctrl) begin
      rd_value[SEL_MSB:SEL_LSB]  = sysclk_select;
      rd_value[FAST_KEEP_BIT]    = fast_osc_halt_keep;
      rd_value[SLOW_KEEP_BIT]    = slow_osc_halt_keep;
    end else if (hit_fast) begin
      rd_value[FAST_STABLE_BIT]  = fast_osc_stable_flag;
      rd_value[FAST_EN_BIT]      = fast_osc_enable;
    end else if (hit_stat) begin
      rd_value[PDF_BIT]          = power_down_flag;
      rd_value[TIMEOUT_BIT]      = watchdog_timeout_flag;
      rd_value[CAUSE_LSB+2:CAUSE_LSB] = last_cause;
    end else if (hit_wake) begin
      rd_value[NPINS-1:0]        = port_wake_enable;
    end
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= rd_value;
      PSLVERR <= !mapped;
    end
  end

  // Zero wait states
  assign PREADY = 1'b1;

  // Control register writes
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sysclk_select      <= SEL_RESET;
      fast_osc_halt_keep <= FAST_KEEP_RESET;
      slow_osc_halt_keep <= SLOW_KEEP_RESET;
      fast_osc_enable    <= FAST_EN_RESET;
      port_wake_enable   <= '0;
    end else begin
      if (wr_ctrl) begin
        sysclk_select      <= PWDATA[SEL_MSB:SEL_LSB];
        fast_osc_halt_keep <= PWDATA[FAST_KEEP_BIT];
        slow_osc_halt_keep <= PWDATA[SLOW_KEEP_BIT];
      end
      if (wr_fast) begin
        fast_osc_enable    <= PWDATA[FAST_EN_BIT];
      end
      if (wr_wake) begin
        port_wake_enable   <= PWDATA[NPINS-1:0];
      end
    end
  end

  // Oscillator run requests per state
  osc_run_t          osc_run;
  always_comb begin
    osc_run.fast = 1'b0;
    osc_run.slow = 1'b1;
    case (state)
      ST_RUN: begin
        // Slow mode leaves the fast oscillator to its enable bit
        osc_run.fast = (sysclk_select != SEL_LOW_SPEED) ||
                       fast_osc_enable;
        osc_run.slow = 1'b1;
      end
      ST_SLEEP: begin
        osc_run.fast = 1'b0;
        osc_run.slow = WDT_ENABLE;
      end
      ST_HALT_SLOW_CLOCK_ON: begin
        osc_run.fast = 1'b0;
        osc_run.slow = 1'b1;
      end
      ST_HALT_BOTH_CLOCKS_ON: begin
        osc_run.fast = 1'b1;
        osc_run.slow = 1'b1;
      end
      ST_HALT_FAST_CLOCK_ON: begin
        osc_run.fast = 1'b1;
        osc_run.slow = 1'b0;
      end
      ST_WAKE: begin
        // Restart the source the system clock needs
        osc_run.fast = !use_slow || fast_osc_enable;
        osc_run.slow = 1'b1;
      end
      default: begin
        osc_run.fast = 1'b1;
        osc_run.slow = 1'b1;
      end
    endcase
  end

  // Stable flag: drops when the oscillator stops or restarts
  wire               fast_restart = osc_run.fast && !fast_run_prev;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      fast_run_prev        <= 1'b0;
      fast_osc_stable_flag <= 1'b0;
    end else begin
      fast_run_prev <= osc_run.fast;
      if (!osc_run.fast || fast_restart) begin
        fast_osc_stable_flag <= 1'b0;
      end else if (fast_rdy_sync) begin
        fast_osc_stable_flag <= 1'b1;
      end
    end
  end

  // Clock source switch; slow only once its oscillator is stable
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      use_slow <= 1'b0;
    end else if (wr_ctrl &&
                 PWDATA[SEL_MSB:SEL_LSB] != SEL_LOW_SPEED) begin
      // Leaving slow acts at the write, no lagging slow cycle
      use_slow <= 1'b0;
    end else if (sysclk_select == SEL_LOW_SPEED) begin
      if (slow_rdy_sync) begin
        use_slow <= 1'b1;
      end
    end else begin
      // Software polls the stable flag before relying on speed
      use_slow <= 1'b0;
    end
  end

  // Wake events
  wire [NPINS-1:0]   pin_fall  = pin_prev & ~pin_sync;
  wire               pin_wake  = |(pin_fall & port_wake_enable);
  // Requests already raised at entry do not wake
  wire [NIRQ-1:0]    new_irq   = IRQ_FLAGS & ~irq_masked;
  wire               irq_wake  = |new_irq;
  wire               any_wake  = pin_wake || irq_wake ||
                                 WDT_OVERFLOW;
  wire               src_ready = use_slow ? slow_rdy_sync
                                          : fast_osc_stable_flag;
  wire               in_idle   = halted && (state != ST_WAKE);
  wire               release_cpu = (state == ST_WAKE) && src_ready;
  wire               irq_serviceable = |(new_irq & IRQ_ENABLES) &&
                                       !STACK_FULL;

  // Next power state
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (HALT) begin
          // Keep bits pick the halt state
          case ({fast_osc_halt_keep, slow_osc_halt_keep})
            2'b00:   next_state = ST_SLEEP;
            2'b01:   next_state = ST_HALT_SLOW_CLOCK_ON;
            2'b11:   next_state = ST_HALT_BOTH_CLOCKS_ON;
            default: next_state = ST_HALT_FAST_CLOCK_ON;
          endcase
        end
      end
      ST_WAKE: begin
        if (src_ready) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        if (any_wake) begin
          next_state = ST_WAKE;
        end
      end
    endcase
  end

  // State, entry mask and wake cause
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state      <= ST_RUN;
      irq_masked <= '0;
      cause      <= '0;
    end else begin
      state <= next_state;
      if (state == ST_RUN && HALT) begin
        irq_masked <= IRQ_FLAGS;
        cause      <= '0;
      end else if (in_idle && any_wake) begin
        cause.pin  <= pin_wake;
        cause.irq  <= irq_wake;
        cause.wdt  <= WDT_OVERFLOW;
      end
    end
  end

  // Status flags; only reset and clear-watchdog drop power-down
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      power_down_flag       <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      last_cause            <= '0;
    end else begin
      if (state == ST_RUN && HALT) begin
        power_down_flag       <= 1'b1;
        watchdog_timeout_flag <= 1'b0;
      end else if (in_idle && WDT_OVERFLOW) begin
        // Other flags keep their values
        watchdog_timeout_flag <= 1'b1;
      end else if (CLR_WDT && !halted) begin
        power_down_flag       <= 1'b0;
      end
      if (release_cpu) begin
        last_cause <= cause;
      end
    end
  end

  // Wake-up results pulse one cycle at release; watchdog clear pulses at halt entry
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      RESUME_NEXT <= 1'b0;
      TAKE_IRQ    <= 1'b0;
      RESET_PC_SP <= 1'b0;
      WDT_CLEAR   <= 1'b0;
    end else begin
      // Watchdog wake restarts at the reset vector
      RESET_PC_SP <= release_cpu && cause.wdt;
      // Serviceable interrupt is taken straight away
      TAKE_IRQ    <= release_cpu && !cause.wdt &&
                     cause.irq && irq_serviceable;
      // Pin wake or blocked interrupt continues after the halt
      RESUME_NEXT <= release_cpu && !cause.wdt &&
                     !(cause.irq && irq_serviceable);
      // Halt always clears the watchdog counter
      WDT_CLEAR   <= (state == ST_RUN) && HALT;
    end
  end

  // Outputs to clocks and core
  assign CPU_CLK_EN      = (state == ST_RUN);
  assign FAST_OSC_RUN    = osc_run.fast;
  assign SLOW_OSC_RUN    = osc_run.slow;
  assign SYSCLK_DIV_SEL  = sysclk_select;
  assign SYSCLK_USE_SLOW = use_slow;
  // Counter runs after a halt only if enabled
  assign WDT_RUN         = WDT_ENABLE;
  assign POWER_MODE      = state;

endmodule
`default_nettype wire

// ---- verification/core_osc_model.sv ----
// Purpose: Processor core pulses and the two on-chip oscillators.
// Assumes: Oscillators settle a fixed number of cycles after start.
// Notes:   Stop clears the count at the next edge, so ready drops one cycle later.
`timescale 1ns/1ps
`default_nettype none
module core_osc_model #(
  parameter int FAST_DLY = 6,
  parameter int SLOW_DLY = 4
) (
  // Clock
  input  wire logic clk,
  // Core instruction pulses
  output logic      halt,
  output logic      clr_wdt,
  // Oscillators
  input  wire logic fast_run,
  input  wire logic slow_run,
  output logic      fast_ready,
  output logic      slow_ready
);
  int fast_cnt;  // Cycles since fast start
  int slow_cnt;  // Cycles since slow start

  initial begin
    halt     = 1'h0;
    clr_wdt  = 1'h0;
    fast_cnt = 0;
    slow_cnt = 0;
  end

  // Settling counters; a slow start means the core must poll
  always @(posedge clk) begin
    fast_cnt <= !fast_run ? 0 : fast_cnt < FAST_DLY ? fast_cnt + 1 : fast_cnt;
    slow_cnt <= !slow_run ? 0 : slow_cnt < SLOW_DLY ? slow_cnt + 1 : slow_cnt;
  end
  assign fast_ready = fast_cnt == FAST_DLY;
  assign slow_ready = slow_cnt == SLOW_DLY;

  // One-cycle halt or clear-watchdog instruction
  task automatic pulse(input logic is_halt);
    @(posedge clk);
    if (is_halt) begin
      halt <= 1'h1;
    end else begin
      clr_wdt <= 1'h1;
    end
    @(posedge clk);
    halt    <= 1'h0;
    clr_wdt <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ---- verification/sysclk_checker.sv ----
// Purpose: Port-level checks for the clock and power-mode controller.
// Assumes: Zero-wait APB; shadows follow writes taken in RUN only.
// Notes:   Bound to the controller at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module sysclk_checker
  import sysclk_pkg::*;
#(
  parameter int NPINS = 14,
  parameter int NIRQ  = 8
) (
  // Clock, reset and APB
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  // Core and watchdog
  input wire logic        HALT,
  input wire logic        WDT_ENABLE,
  input wire logic        WDT_CLEAR,
  input wire logic        WDT_RUN,
  // Oscillators and system clock
  input wire logic        FAST_OSC_RUN,
  input wire logic        SLOW_OSC_RUN,
  input wire logic        CPU_CLK_EN,
  input wire logic [2:0]  SYSCLK_DIV_SEL,
  input wire logic        SYSCLK_USE_SLOW,
  // Wake results
  input wire logic        RESUME_NEXT,
  input wire logic        TAKE_IRQ,
  input wire logic        RESET_PC_SP,
  input wire logic [2:0]  POWER_MODE
);
  logic [2:0] sel_sh;   // Select field shadow
  logic [1:0] keep_sh;  // Halt-keep bits shadow
  logic       fen_sh;   // Fast enable shadow
  // Writes while halted are dropped, so the shadow drops them too
  wire logic       wr_ok = PSEL && PENABLE && PWRITE && PREADY
                           && POWER_MODE == 3'h0;
  wire logic [2:0] halt_mode = keep_sh == 2'h0 ? 3'h1 :
                               keep_sh == 2'h1 ? 3'h2 :
                               keep_sh == 2'h3 ? 3'h3 : 3'h4;
  // Expected {fast, slow} run requests per halt state
  wire logic [1:0] osc_exp = POWER_MODE == 3'h1 ? {1'h0, WDT_ENABLE} :
                             POWER_MODE == 3'h2 ? 2'h1 :
                             POWER_MODE == 3'h3 ? 2'h3 : 2'h2;
  wire logic       any_res = RESUME_NEXT || TAKE_IRQ || RESET_PC_SP;

  // Shadow registers
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sel_sh  <= SEL_RESET;
      keep_sh <= {FAST_KEEP_RESET, SLOW_KEEP_RESET};
      fen_sh  <= FAST_EN_RESET;
    end else if (wr_ok && PADDR == SYSCLK_CTRL_OFS) begin
      sel_sh  <= PWDATA[SEL_MSB:SEL_LSB];
      keep_sh <= PWDATA[1:0];
    end else if (wr_ok && PADDR == FAST_OSC_OFS) begin
      fen_sh <= PWDATA[FAST_EN_BIT];
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  chk_halt_mode:
    assert property (HALT && POWER_MODE == 3'h0 |=> POWER_MODE == halt_mode)
    else $error("halt entered wrong state");
  chk_cpu_gate:
    assert property (CPU_CLK_EN == (POWER_MODE == 3'h0))
    else $error("cpu clock enable wrong");
  chk_wdt_clear:
    assert property (HALT && POWER_MODE == 3'h0 |=> WDT_CLEAR ##1 !WDT_CLEAR)
    else $error("watchdog clear pulse wrong");
  chk_wdt_run:
    assert property (WDT_RUN == WDT_ENABLE)
    else $error("watchdog run wrong");
  chk_halt_osc:
    assert property (POWER_MODE inside {[3'h1:3'h4]}
                     |-> {FAST_OSC_RUN, SLOW_OSC_RUN} == osc_exp)
    else $error("oscillator run wrong while halted");
  chk_regs_hold:
    assert property (POWER_MODE != 3'h0 |=> $stable(SYSCLK_DIV_SEL))
    else $error("select changed while halted");
  chk_wake_onehot:
    assert property (POWER_MODE == 3'h0 && $past(POWER_MODE) == 3'h5
                     |-> $onehot({RESUME_NEXT, TAKE_IRQ, RESET_PC_SP}))
    else $error("wake result not single");
  chk_result_when:
    assert property (any_res |-> POWER_MODE == 3'h0 ##1 !any_res)
    else $error("wake result out of place");
  chk_slow_source:
    assert property (SYSCLK_USE_SLOW |-> sel_sh == SEL_LOW_SPEED)
    else $error("slow source without code 7");
  chk_div_select:
    assert property (sel_sh != SEL_LOW_SPEED |-> SYSCLK_DIV_SEL == sel_sh)
    else $error("divider select wrong");
  chk_slow_fast_en:
    assert property (SYSCLK_USE_SLOW && POWER_MODE == 3'h0
                     |-> FAST_OSC_RUN == fen_sh)
    else $error("fast run ignores enable in slow mode");
endmodule

bind sysclk_power_mode_ctrl sysclk_checker #(.NPINS(NPINS), .NIRQ(NIRQ))
  sysclk_checker_i (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .HALT(HALT), .WDT_ENABLE(WDT_ENABLE),
  .WDT_CLEAR(WDT_CLEAR), .WDT_RUN(WDT_RUN), .FAST_OSC_RUN(FAST_OSC_RUN),
  .SLOW_OSC_RUN(SLOW_OSC_RUN), .CPU_CLK_EN(CPU_CLK_EN),
  .SYSCLK_DIV_SEL(SYSCLK_DIV_SEL), .SYSCLK_USE_SLOW(SYSCLK_USE_SLOW),
  .RESUME_NEXT(RESUME_NEXT), .TAKE_IRQ(TAKE_IRQ),
  .RESET_PC_SP(RESET_PC_SP), .POWER_MODE(POWER_MODE));
`default_nettype wire

// ---- verification/test_sysclk_power_mode_ctrl.sv ----
// Purpose: Register, clock switch, halt and wake-up scenarios.
// Assumes: Zero-wait APB slave; core model gives halt pulses.
// Notes:   Only mismatches, wait timeouts and the verdict are printed.
`timescale 1ns/1ps
`default_nettype none
module test_sysclk_power_mode_ctrl
  import sysclk_pkg::*;
;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, irq_flags, irq_enables;
  logic [31:0] pwdata, prdata, rd;
  logic        halt, clr_wdt, stack_full, wdt_enable, wdt_overflow;
  logic        wdt_clear, wdt_run, fast_ready, slow_ready, fast_run;
  logic        slow_run, cpu_clk_en, use_slow, resume_next, take_irq;
  logic        reset_pc_sp;
  logic [13:0] port_pins;
  logic [2:0]  div_sel, power_mode;
  int          num_errors, comparisons, i, n;

  sysclk_power_mode_ctrl sysclk_power_mode_ctrl_i (
    .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .HALT(halt), .CLR_WDT(clr_wdt),
    .IRQ_FLAGS(irq_flags), .IRQ_ENABLES(irq_enables),
    .STACK_FULL(stack_full), .WDT_ENABLE(wdt_enable),
    .WDT_OVERFLOW(wdt_overflow), .WDT_CLEAR(wdt_clear), .WDT_RUN(wdt_run),
    .PORT_PINS(port_pins), .FAST_OSC_READY(fast_ready),
    .SLOW_OSC_READY(slow_ready), .FAST_OSC_RUN(fast_run),
    .SLOW_OSC_RUN(slow_run), .CPU_CLK_EN(cpu_clk_en),
    .SYSCLK_DIV_SEL(div_sel), .SYSCLK_USE_SLOW(use_slow),
    .RESUME_NEXT(resume_next), .TAKE_IRQ(take_irq),
    .RESET_PC_SP(reset_pc_sp), .POWER_MODE(power_mode));

  core_osc_model core_osc_model_i (
    .clk(clk), .halt(halt), .clr_wdt(clr_wdt), .fast_run(fast_run),
    .slow_run(slow_run), .fast_ready(fast_ready), .slow_ready(slow_ready));

  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic results();
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic fail_wait();
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'h1) break;
    end
    if (k == 20) fail_wait();
    rd = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask

  // Software polls the stable flag after a fast restart
  task automatic poll_stable();
    int k;
    for (k = 0; k < 40; k++) begin
      apb(1'h0, FAST_OSC_OFS, 32'h0);
      if (rd === 32'h3) break;
    end
    if (k == 40) fail_wait();
  endtask

  // Halt with keep bits k, wake by pin (0), irq (1) or watchdog (2)
  task automatic cycle(input logic [1:0] k, input int how,
                       input logic [2:0] res);
    logic [2:0] m;
    int         w;
    m = k == 2'h0 ? 3'h1 : k == 2'h1 ? 3'h2 : k == 2'h3 ? 3'h3 : 3'h4;
    apb(1'h1, SYSCLK_CTRL_OFS, {30'h0, k});
    core_osc_model_i.pulse(1'h1);
    #1;
    check(power_mode, m);
    check(cpu_clk_en, 1'h0);
    apb(1'h0, PWR_STATUS_OFS, 32'h0);
    check(rd[1:0], 2'h1);
    apb(1'h1, SYSCLK_CTRL_OFS, 32'hE3);
    rdchk(SYSCLK_CTRL_OFS, {30'h0, k});
    check(power_mode, m);
    case (how)
      0: port_pins[0] <= 1'h0;
      1: irq_flags[0] <= 1'h1;
      default: wdt_overflow <= 1'h1;
    endcase
    for (w = 0; w < 60; w++) begin
      @(posedge clk);
      #1;
      if (power_mode === 3'h0) break;
      check(cpu_clk_en, 1'h0);
    end
    if (w == 60) fail_wait();
    check({reset_pc_sp, take_irq, resume_next}, res);
    apb(1'h0, PWR_STATUS_OFS, 32'h0);
    check(rd[1:0], how == 2 ? 2'h3 : 2'h1);
    @(posedge clk);
    port_pins    <= 14'h3FFF;
    irq_flags    <= 8'h0;
    wdt_overflow <= 1'h0;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    stack_full = 1'h0;
    wdt_enable = 1'h0;
    wdt_overflow = 1'h0;
    irq_flags = 8'h0;
    irq_enables = 8'h0;
    port_pins = 14'h3FFF;
    num_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    rdchk(SYSCLK_CTRL_OFS, 32'h0);
    rdchk(PWR_STATUS_OFS, 32'h0);
    rdchk(8'h10, 32'h0);
    check(pslverr, 1'h1);
    poll_stable();
    apb(1'h1, SYSCLK_CTRL_OFS, 32'hFF);
    rdchk(SYSCLK_CTRL_OFS, 32'hE3);
    apb(1'h1, FAST_OSC_OFS, 32'hFF);
    rdchk(FAST_OSC_OFS, 32'h3);
    for (i = 0; i < 7; i++) begin
      apb(1'h1, SYSCLK_CTRL_OFS, 32'(i << 5));
      #1;
      check(div_sel, i[2:0]);
      check(use_slow, 1'h0);
    end
    // Over to the slow source, then fast off
    apb(1'h1, SYSCLK_CTRL_OFS, 32'hE0);
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      #1;
      if (use_slow === 1'h1) break;
    end
    if (n == 20) fail_wait();
    apb(1'h1, FAST_OSC_OFS, 32'h0);
    rdchk(FAST_OSC_OFS, 32'h0);
    check(fast_run, 1'h0);
    apb(1'h1, FAST_OSC_OFS, 32'h1);
    rdchk(FAST_OSC_OFS, 32'h1);
    poll_stable();
    apb(1'h1, SYSCLK_CTRL_OFS, 32'h0);
    #1;
    check(use_slow, 1'h0);
    apb(1'h1, WAKE_ENABLE_OFS, 32'h1);
    rdchk(WAKE_ENABLE_OFS, 32'h1);
    cycle(2'h0, 0, 3'h1);
    wdt_enable <= 1'h1;
    cycle(2'h1, 0, 3'h1);
    irq_enables <= 8'h1;
    cycle(2'h3, 1, 3'h2);
    stack_full <= 1'h1;
    cycle(2'h2, 1, 3'h1);
    stack_full  <= 1'h0;
    irq_enables <= 8'h0;
    cycle(2'h3, 1, 3'h1);
    @(posedge clk);
    irq_flags <= 8'h1;
    cycle(2'h0, 2, 3'h4);
    core_osc_model_i.pulse(1'h0);
    apb(1'h0, PWR_STATUS_OFS, 32'h0);
    check(rd[0], 1'h0);
    results();
  end
endmodule
`default_nettype wire
